// file: rtl/sfdpr_top.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// (RL1) Byte 10h reads EEh, no fast modes.
// (RL2) Reserved bytes 11h-15h, 18h, 19h read FFh.
// (RL3) Bytes 16h, 17h read FFh, no all-dual.
// (RL4) Bytes 1Ah, 1Bh read FFh, no four-lane.
// (RL5) Byte 1Ch reads 0Ch, 4 kB sector.
// (RL6) Byte 1Dh reads 20h erase opcode.
// (RL7) Byte 1Eh reads 10h, 64 kB sector.
// (RL8) Byte 1Fh reads D8h erase opcode.
// (RL9) Sectors three and four marked absent.
// (RL10) Unit codes mean 1, 16, 128, 1000 ms.
// (RL11) Typical time is (count+1) times unit.
// (RL12) Sector two erase takes 496 ms typical.
// (RL13) Sector three/four time fields all ones.
// (RL14) Multiplier field 0010b, byte 24h reads 42h.
// (RL15) Parameter reads auto-increment the address.
// (RL16) Host assembles dwords little-endian.
module sfdpr_top
   import sfdpr_pkg::*;
#(
   parameter int ADDR_W = ADDR_WIDTH,
   parameter int DATA_W = DATA_WIDTH,
   parameter int TIME_W = TIME_WIDTH
)(
   // Clock and reset.
   input  wire logic              mclk,
   input  wire logic              srst,
   // Register port.
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data
);
   // The table and the byte-wide port are fixed at eight bits.
   if (ADDR_W != ADDR_WIDTH || DATA_W != DATA_WIDTH) begin : g_chk_bus
      $error("sfdpr_top: bus widths must stay at eight bits");
   end
   if (TIME_W < 21 || TIME_W > 3 * DATA_WIDTH) begin : g_chk_time
      $error("sfdpr_top: TIME_W must lie in 21..24");
   end

   logic [ADDR_W-1:0] ptr_reg;
   logic [ADDR_W-1:0] ptr_next;
   logic [1:0]        sel_reg;
   logic [1:0]        sel_next;
   logic              ovr_reg;
   logic              ovr_next;
   logic [DATA_W-1:0] rd_data_reg;
   logic [DATA_W-1:0] rd_data_next;

   // Two lookups: one for direct reads, one behind the stream pointer.
   sfdpr_rom_if bus_lk ();
   sfdpr_rom_if ptr_lk ();

   assign bus_lk.addr = addr;
   assign ptr_lk.addr = ptr_reg;

   sfdpr_rom u_rom_bus (
      .lk (bus_lk)
   );

   sfdpr_rom u_rom_ptr (
      .lk (ptr_lk)
   );

   // Erase times decoded for every sector type, chosen by the select.
   logic [TIME_W-1:0] typ_ms [SECTORS];
   logic [TIME_W-1:0] max_ms [SECTORS];

   for (genvar k = 0; k < SECTORS; k++) begin : g_dec
      localparam int B = ET_FIELD_BASE + k * ET_FIELD_STEP;
      sfdpr_erase_dec #(
         .TIME_W (TIME_W)
      ) u_dec (
         .unit   (ERASE_DWORD[B+6:B+5]),
         .cnt    (ERASE_DWORD[B+4:B]),
         .mult   (ERASE_DWORD[3:0]),
         .typ_ms (typ_ms[k]),
         .max_ms (max_ms[k])
      );
   end

   logic [23:0] typ_sel;
   logic [23:0] max_sel;

   assign typ_sel = 24'(typ_ms[sel_reg]);
   assign max_sel = 24'(max_ms[sel_reg]);

   logic data_rd;
   logic ptr_wr;
   logic stat_wr;

   assign data_rd = rd_en && (addr == REG_DATA);
   assign ptr_wr  = wr_en && (addr == REG_PTR);
   assign stat_wr = wr_en && (addr == REG_STAT);

   always_comb begin
      ptr_next = ptr_reg;
      sel_next = sel_reg;
      ovr_next = ovr_reg;
      if (ptr_wr) begin
         ptr_next = wr_data;
      end else if (data_rd) begin
         ptr_next = ptr_reg + 8'h01; // RL15
      end
      if (wr_en && addr == REG_SEL) begin
         sel_next = wr_data[1:0];
      end
      // A stream read past the table beats a clear in the same cycle.
      if (stat_wr && wr_data[STAT_OVERRUN]) begin
         ovr_next = 1'b0;
      end
      if (data_rd && !ptr_lk.hit) begin
         ovr_next = 1'b1;
      end
   end

   // Read data stands only in the cycle after the read strobe.
   always_comb begin
      rd_data_next = '0;
      if (rd_en) begin
         case (addr)
            REG_PTR:  rd_data_next = ptr_reg;
            REG_DATA: rd_data_next = ptr_lk.data; // RL15
            REG_STAT: begin
               rd_data_next[STAT_IN_TABLE] = ptr_lk.hit;
               rd_data_next[STAT_OVERRUN]  = ovr_reg;
            end
            REG_SEL:  rd_data_next = {6'h00, sel_reg};
            REG_TYP0: rd_data_next = typ_sel[7:0]; // RL11
            REG_TYP1: rd_data_next = typ_sel[15:8];
            REG_TYP2: rd_data_next = typ_sel[23:16];
            REG_MAX0: rd_data_next = max_sel[7:0]; // RL14
            REG_MAX1: rd_data_next = max_sel[15:8];
            REG_MAX2: rd_data_next = max_sel[23:16];
            default:  rd_data_next = bus_lk.data;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ptr_reg     <= PTR_RESET;
         sel_reg     <= SEL_RESET;
         ovr_reg     <= 1'b0;
         rd_data_reg <= '0;
      end else begin
         ptr_reg     <= ptr_next;
         sel_reg     <= sel_next;
         ovr_reg     <= ovr_next;
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   property p_mode_flags; // RL1
      rd_en && addr == 8'h10 |=> rd_data == 8'hEE;
   endproperty
   a_mode_flags: assert property (p_mode_flags) // RL1
      else $error("byte 10h does not read EEh");

   property p_reserved; // RL2
      rd_en && (addr inside {8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h19})
      |=> rd_data == 8'hFF;
   endproperty
   a_reserved: assert property (p_reserved) // RL2
      else $error("reserved byte does not read FFh");

   property p_all_dual; // RL3
      rd_en && (addr == 8'h16 || addr == 8'h17) |=> rd_data == 8'hFF;
   endproperty
   a_all_dual: assert property (p_all_dual) // RL3
      else $error("all-dual byte does not read FFh");

   property p_four_lane; // RL4
      rd_en && (addr == 8'h1A || addr == 8'h1B) |=> rd_data == 8'hFF;
   endproperty
   a_four_lane: assert property (p_four_lane) // RL4
      else $error("four-lane byte does not read FFh");

   property p_s1_size; // RL5
      rd_en && addr == 8'h1C |=> rd_data == 8'h0C;
   endproperty
   a_s1_size: assert property (p_s1_size) // RL5
      else $error("byte 1Ch does not read 0Ch");

   property p_s1_opc; // RL6
      rd_en && addr == 8'h1D |=> rd_data == 8'h20;
   endproperty
   a_s1_opc: assert property (p_s1_opc) // RL6
      else $error("byte 1Dh does not read 20h");

   property p_s2_size; // RL7
      rd_en && addr == 8'h1E |=> rd_data == 8'h10;
   endproperty
   a_s2_size: assert property (p_s2_size) // RL7
      else $error("byte 1Eh does not read 10h");

   property p_s2_opc; // RL8
      rd_en && addr == 8'h1F |=> rd_data == 8'hD8;
   endproperty
   a_s2_opc: assert property (p_s2_opc) // RL8
      else $error("byte 1Fh does not read D8h");

   property p_absent; // RL9
      rd_en && (addr == 8'h20 || addr == 8'h22) |=> rd_data == 8'h00;
   endproperty
   a_absent: assert property (p_absent) // RL9
      else $error("absent sector size is not 00h");

   property p_absent_opc; // RL9
      rd_en && (addr == 8'h21 || addr == 8'h23) |=> rd_data == 8'hFF;
   endproperty
   a_absent_opc: assert property (p_absent_opc) // RL9
      else $error("absent sector opcode is not FFh");

   property p_unit_1s; // RL10
      wr_en && addr == 8'h03 && wr_data == 8'h03
      ##1 rd_en && addr == 8'h05 |=> rd_data == 8'h7D;
   endproperty
   a_unit_1s: assert property (p_unit_1s) // RL10
      else $error("one-second unit does not decode to 32000 ms");

   property p_typ_s1; // RL11
      sel_reg == 2'h0 && rd_en && addr == 8'h04 |=> rd_data == 8'h50;
   endproperty
   a_typ_s1: assert property (p_typ_s1) // RL11
      else $error("sector one typical time is not 80 ms");

   property p_typ_s2; // RL12
      sel_reg == 2'h1 && rd_en && addr == 8'h04 ##1 rd_data == 8'hF0
      ##0 rd_en && addr == 8'h05 |=> rd_data == 8'h01;
   endproperty
   a_typ_s2: assert property (p_typ_s2) // RL12
      else $error("sector two typical time is not 496 ms");

   property p_rsvd_time; // RL13
      rd_en && (addr == 8'h26 || addr == 8'h27) |=> rd_data[7:2] == 6'h3F;
   endproperty
   a_rsvd_time: assert property (p_rsvd_time) // RL13
      else $error("reserved erase-time fields are not ones");

   property p_erase_low; // RL14
      rd_en && addr == 8'h24 |=> rd_data == 8'h42;
   endproperty
   a_erase_low: assert property (p_erase_low) // RL14
      else $error("byte 24h does not read 42h");

   property p_max_s1; // RL14
      sel_reg == 2'h0 && rd_en && addr == 8'h07 |=> rd_data == 8'hE0;
   endproperty
   a_max_s1: assert property (p_max_s1) // RL14
      else $error("sector one maximum time is not 480 ms");

   property p_stream; // RL15
      wr_en && addr == 8'h00 && wr_data == 8'h1C
      ##1 rd_en && addr == 8'h01 [*2]
      |=> rd_data == 8'h20 && ptr_reg == 8'h1E;
   endproperty
   a_stream: assert property (p_stream) // RL15
      else $error("stream read did not advance by one byte");

   property p_advance; // RL15
      rd_en && addr == 8'h01 |=> ptr_reg == $past(ptr_reg) + 8'h01;
   endproperty
   a_advance: assert property (p_advance) // RL15
      else $error("pointer did not step after a stream read");

endmodule : sfdpr_top

// file: inc/sfdpr_pkg.sv
package sfdpr_pkg;

   // Bus and table geometry.
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 8;
   localparam int TIME_WIDTH = 24;
   localparam int SEL_WIDTH  = 2;
   localparam int SECTORS    = 4;

   // Control registers of the read path.
   localparam logic [7:0] REG_PTR  = 8'h00;
   localparam logic [7:0] REG_DATA = 8'h01;
   localparam logic [7:0] REG_STAT = 8'h02;
   localparam logic [7:0] REG_SEL  = 8'h03;
   localparam logic [7:0] REG_TYP0 = 8'h04;
   localparam logic [7:0] REG_TYP1 = 8'h05;
   localparam logic [7:0] REG_TYP2 = 8'h06;
   localparam logic [7:0] REG_MAX0 = 8'h07;
   localparam logic [7:0] REG_MAX1 = 8'h08;
   localparam logic [7:0] REG_MAX2 = 8'h09;
   localparam int STAT_IN_TABLE = 0;
   localparam int STAT_OVERRUN  = 1;
   localparam logic [7:0] PTR_RESET = 8'h10;
   localparam logic [1:0] SEL_RESET = 2'h0;

   // Parameter table offsets.
   localparam logic [7:0] OFS_MODE_FLAGS  = 8'h10;
   localparam logic [7:0] OFS_RSVD_A1     = 8'h11;
   localparam logic [7:0] OFS_RSVD_A2     = 8'h12;
   localparam logic [7:0] OFS_RSVD_A3     = 8'h13;
   localparam logic [7:0] OFS_RSVD_B0     = 8'h14;
   localparam logic [7:0] OFS_RSVD_B1     = 8'h15;
   localparam logic [7:0] OFS_DUAL_CYC    = 8'h16;
   localparam logic [7:0] OFS_DUAL_OPC    = 8'h17;
   localparam logic [7:0] OFS_RSVD_C0     = 8'h18;
   localparam logic [7:0] OFS_RSVD_C1     = 8'h19;
   localparam logic [7:0] OFS_QUAD_CYC    = 8'h1A;
   localparam logic [7:0] OFS_QUAD_OPC    = 8'h1B;
   localparam logic [7:0] OFS_S1_SIZE     = 8'h1C;
   localparam logic [7:0] OFS_S1_OPC      = 8'h1D;
   localparam logic [7:0] OFS_S2_SIZE     = 8'h1E;
   localparam logic [7:0] OFS_S2_OPC      = 8'h1F;
   localparam logic [7:0] OFS_S3_SIZE     = 8'h20;
   localparam logic [7:0] OFS_S3_OPC      = 8'h21;
   localparam logic [7:0] OFS_S4_SIZE     = 8'h22;
   localparam logic [7:0] OFS_S4_OPC      = 8'h23;
   localparam logic [7:0] OFS_ERASE_B0    = 8'h24;
   localparam logic [7:0] OFS_ERASE_B1    = 8'h25;
   localparam logic [7:0] OFS_ERASE_B2    = 8'h26;
   localparam logic [7:0] OFS_ERASE_B3    = 8'h27;

   // Parameter table contents.
   localparam logic [7:0] VAL_MODE_FLAGS = 8'hEE;
   localparam logic [7:0] VAL_ONES       = 8'hFF;
   localparam logic [7:0] VAL_ABSENT     = 8'h00;
   localparam logic [7:0] VAL_S1_SIZE    = 8'h0C;
   localparam logic [7:0] VAL_S1_OPC     = 8'h20;
   localparam logic [7:0] VAL_S2_SIZE    = 8'h10;
   localparam logic [7:0] VAL_S2_OPC     = 8'hD8;

   // Erase time encoding.
   localparam logic [1:0] ET_UNIT_1MS   = 2'b00;
   localparam logic [1:0] ET_UNIT_16MS  = 2'b01;
   localparam logic [1:0] ET_UNIT_128MS = 2'b10;
   localparam logic [1:0] ET_UNIT_1S    = 2'b11;
   localparam logic [TIME_WIDTH-1:0] MS_1    = 24'h00_0001;
   localparam logic [TIME_WIDTH-1:0] MS_16   = 24'h00_0010;
   localparam logic [TIME_WIDTH-1:0] MS_128  = 24'h00_0080;
   localparam logic [TIME_WIDTH-1:0] MS_1000 = 24'h00_03E8;
   localparam logic [TIME_WIDTH-1:0] ET_MAX_FACTOR = 24'h00_0002;
   localparam logic [4:0] ET1_CNT     = 5'b00100;
   localparam logic [4:0] ET2_CNT     = 5'b11110;
   localparam logic [4:0] ET_RSVD_CNT = 5'b11111;
   localparam logic [3:0] ET_MULT     = 4'b0010;
   localparam int ET_FIELD_BASE = 4;
   localparam int ET_FIELD_STEP = 7;
   localparam logic [31:0] ERASE_DWORD = {ET_UNIT_1S, ET_RSVD_CNT, ET_UNIT_1S, ET_RSVD_CNT,
                                          ET_UNIT_16MS, ET2_CNT, ET_UNIT_16MS, ET1_CNT, ET_MULT};

endpackage : sfdpr_pkg

// file: inc/sfdpr_rom_if.sv
`timescale 1ns/1ps
interface sfdpr_rom_if;
   import sfdpr_pkg::*;
   logic [ADDR_WIDTH-1:0] addr;
   logic [DATA_WIDTH-1:0] data;
   logic                  hit;
   modport rom  (input addr, output data, output hit);
   modport user (output addr, input data, input hit);
endinterface : sfdpr_rom_if

// file: rtl/sfdpr_rom.sv
`timescale 1ns/1ps
module sfdpr_rom
   import sfdpr_pkg::*;
(
   // Lookup port.
   sfdpr_rom_if.rom lk
);
   always_comb begin
      lk.hit = 1'b1;
      case (lk.addr)
         OFS_MODE_FLAGS: lk.data = VAL_MODE_FLAGS; // RL1
         OFS_RSVD_A1, OFS_RSVD_A2, OFS_RSVD_A3,
         OFS_RSVD_B0, OFS_RSVD_B1,
         OFS_RSVD_C0, OFS_RSVD_C1: lk.data = VAL_ONES; // RL2
         OFS_DUAL_CYC, OFS_DUAL_OPC: lk.data = VAL_ONES; // RL3
         OFS_QUAD_CYC, OFS_QUAD_OPC: lk.data = VAL_ONES; // RL4
         OFS_S1_SIZE: lk.data = VAL_S1_SIZE; // RL5
         OFS_S1_OPC: lk.data = VAL_S1_OPC; // RL6
         OFS_S2_SIZE: lk.data = VAL_S2_SIZE; // RL7
         OFS_S2_OPC: lk.data = VAL_S2_OPC; // RL8
         OFS_S3_SIZE, OFS_S4_SIZE: lk.data = VAL_ABSENT; // RL9
         OFS_S3_OPC, OFS_S4_OPC: lk.data = VAL_ONES; // RL9
         OFS_ERASE_B0: lk.data = ERASE_DWORD[7:0]; // RL14
         OFS_ERASE_B1: lk.data = ERASE_DWORD[15:8]; // RL12
         OFS_ERASE_B2: lk.data = ERASE_DWORD[23:16]; // RL13
         OFS_ERASE_B3: lk.data = ERASE_DWORD[31:24]; // RL13
         default: begin
            lk.hit  = 1'b0;
            lk.data = VAL_ABSENT;
         end
      endcase
   end
endmodule : sfdpr_rom

// file: rtl/sfdpr_erase_dec.sv
`timescale 1ns/1ps
module sfdpr_erase_dec
   import sfdpr_pkg::*;
#(
   parameter int TIME_W = TIME_WIDTH
)(
   // Encoded fields.
   input  wire logic [1:0]        unit,
   input  wire logic [4:0]        cnt,
   input  wire logic [3:0]        mult,
   // Decoded times in milliseconds.
   output logic      [TIME_W-1:0] typ_ms,
   output logic      [TIME_W-1:0] max_ms
);
   // The worst case, 32 s times a 32x factor, needs 20 bits; the check asks for 21.
   if (TIME_W < 21) begin : g_chk
      $error("sfdpr_erase_dec: TIME_W too small");
   end

   logic [TIME_W-1:0] unit_ms;

   always_comb begin
      case (unit)
         ET_UNIT_1MS:   unit_ms = TIME_W'(MS_1); // RL10
         ET_UNIT_16MS:  unit_ms = TIME_W'(MS_16);
         ET_UNIT_128MS: unit_ms = TIME_W'(MS_128);
         default:       unit_ms = TIME_W'(MS_1000);
      endcase
      typ_ms = TIME_W'((TIME_W'(cnt) + TIME_W'(1)) * unit_ms); // RL11
      max_ms = TIME_W'(TIME_W'(ET_MAX_FACTOR) * (TIME_W'(mult) + TIME_W'(1)) * typ_ms); // RL14
   end
endmodule : sfdpr_erase_dec

// file: tb/sfdpr_host_model.sv
`timescale 1ns/1ps
// Host side of the register port: bus cycles, dword assembly and erase-time decoding.
module sfdpr_host_model
   import sfdpr_pkg::*;
(
   // Clock.
   input  wire logic                  mclk,
   // Register port, host side.
   output logic      [ADDR_WIDTH-1:0] addr,
   output logic      [DATA_WIDTH-1:0] wr_data,
   output logic                       wr_en,
   output logic                       rd_en,
   input  wire logic [DATA_WIDTH-1:0] rd_data
);
   initial begin
      addr    = 8'h00;
      wr_data = 8'h00;
      wr_en   = 1'b0;
      rd_en   = 1'b0;
   end

   // Called just after a rising edge. A write leaves its strobe up so that the next transfer
   // may follow with no gap; a read or bus_idle takes it down, so no line is set twice at once.
   task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      rd_en   <= 1'b0;
      @(posedge mclk);
   endtask : bus_write

   // Released lines show the inverse so stale values never help.
   task automatic bus_idle();
      wr_en   <= 1'b0;
      rd_en   <= 1'b0;
      addr    <= ~addr;
      wr_data <= ~wr_data;
      @(posedge mclk);
   endtask : bus_idle

   // Back-to-back reads: the strobe stands for n cycles and each byte is taken
   // in the one cycle after the edge that accepted its read.
   task automatic read_seq(input logic [7:0] a, input logic inc, input int n,
                           output logic [31:0] v);
      v = '0;
      fork
         begin
            for (int i = 0; i < n; i++) begin
               addr  <= inc ? 8'(a + 8'(i)) : a;
               rd_en <= 1'b1;
               wr_en <= 1'b0;
               @(posedge mclk);
            end
            rd_en   <= 1'b0;
            addr    <= ~addr;
            wr_data <= ~wr_data;
         end
         begin
            @(posedge mclk);
            for (int j = 0; j < n; j++) begin
               @(negedge mclk);
               v[8*j +: 8] = rd_data;
            end
            @(posedge mclk);
         end
      join
   endtask : read_seq

   task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
      logic [31:0] v;
      read_seq(a, 1'b0, 1, v);
      d = v[7:0];
   endtask : bus_read

   task automatic read_dword(input logic [7:0] start, output logic [31:0] dw);
      logic [31:0] v;
      bus_write(REG_PTR, start);
      read_seq(REG_DATA, 1'b0, 4, v);
      dw = v;
   endtask : read_dword

   task automatic read_time(input logic [7:0] base, output logic [23:0] t);
      logic [31:0] v;
      read_seq(base, 1'b1, 3, v);
      t = v[23:0];
   endtask : read_time

   function automatic logic [31:0] typ_ms(input logic [1:0] u, input logic [4:0] c);
      logic [31:0] unit_ms;
      case (u)
         2'h0:    unit_ms = 32'h0000_0001;
         2'h1:    unit_ms = 32'h0000_0010;
         2'h2:    unit_ms = 32'h0000_0080;
         default: unit_ms = 32'h0000_03E8;
      endcase
      return (32'(c) + 32'h0000_0001) * unit_ms;
   endfunction : typ_ms

   function automatic logic [31:0] max_ms(input logic [3:0] m, input logic [31:0] t);
      return 32'h0000_0002 * (32'(m) + 32'h0000_0001) * t;
   endfunction : max_ms
endmodule : sfdpr_host_model

// file: tb/sfdpr_top_bench.sv
`timescale 1ns/1ps
module sfdpr_top_bench;
   import sfdpr_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
   } sfdpr_row_t;
   logic                  mclk        = 1'b0;
   logic                  srst        = 1'b1;
   logic [ADDR_WIDTH-1:0] addr;
   logic [DATA_WIDTH-1:0] wr_data;
   logic                  wr_en;
   logic                  rd_en;
   logic [DATA_WIDTH-1:0] rd_data;
   int                    err_total   = 0;
   int                    check_count = 0;
   logic [7:0]            b;
   logic [31:0]           w;
   logic [31:0]           exp_w;
   logic [31:0]           typ;
   logic [23:0]           t;
   // Direct reads of the table, then unmapped places that must read zero.
   sfdpr_row_t rows [26] = '{'{8'h10, 8'hEE}, '{8'h11, 8'hFF}, '{8'h12, 8'hFF}, '{8'h13, 8'hFF},
      '{8'h14, 8'hFF}, '{8'h15, 8'hFF}, '{8'h16, 8'hFF}, '{8'h17, 8'hFF}, '{8'h18, 8'hFF},
      '{8'h19, 8'hFF}, '{8'h1A, 8'hFF}, '{8'h1B, 8'hFF}, '{8'h1C, 8'h0C}, '{8'h1D, 8'h20},
      '{8'h1E, 8'h10}, '{8'h1F, 8'hD8}, '{8'h20, 8'h00}, '{8'h21, 8'hFF}, '{8'h22, 8'h00},
      '{8'h23, 8'hFF}, '{8'h24, 8'h42}, '{8'h25, 8'hF2}, '{8'h26, 8'hFD}, '{8'h27, 8'hFF},
      '{8'h0A, 8'h00}, '{8'h80, 8'h00}};

   always #50 mclk = ~mclk;

   sfdpr_top u_dut (.mclk(mclk), .srst(srst), .addr(addr), .wr_data(wr_data),
                    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
   sfdpr_host_model u_host (.mclk(mclk), .addr(addr), .wr_data(wr_data),
                            .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));

   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : chk_byte

   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : chk_word

   task automatic summarize();
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // The whole sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge mclk);
      err_total++;
      summarize();
   end

   initial begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      u_host.bus_read(REG_PTR, b);
      chk_byte("ptr_reset", 8'h10, b);
      u_host.bus_read(REG_STAT, b);
      chk_byte("stat_reset", 8'h01, b);
      u_host.bus_read(REG_SEL, b);
      chk_byte("sel_reset", 8'h00, b);
      // Writes to the read-only table must leave it untouched.
      u_host.bus_write(8'h10, 8'h00);
      u_host.bus_write(8'h24, 8'h00);
      u_host.bus_write(8'h1E, 8'h0F);
      for (int i = 0; i < 26; i++) begin
         u_host.bus_read(rows[i].a, b);
         chk_byte("table_byte", rows[i].d, b);
      end
      // Read data stands for one cycle only.
      u_host.bus_read(8'h1F, b);
      @(negedge mclk);
      chk_byte("rd_data_idle", 8'h00, rd_data);
      @(posedge mclk);
      u_host.read_dword(8'h1C, w);
      chk_word("sector_dword", 32'hD810_200C, w);
      u_host.bus_read(REG_PTR, b);
      chk_byte("ptr_advanced", 8'h20, b);
      exp_w = {2'h3, 5'h1F, 2'h3, 5'h1F, 2'h1, 5'h1E, 2'h1, 5'h04, 4'h2};
      u_host.read_dword(8'h24, w);
      chk_word("erase_dword", exp_w, w);
      chk_word("s1_typ", 32'h0000_0050, u_host.typ_ms(w[10:9], w[8:4]));
      chk_word("s2_typ", 32'h0000_01F0, u_host.typ_ms(w[17:16], w[15:11]));
      // Streaming past the table end flags an overrun, cleared by writing bit 1.
      u_host.bus_read(REG_DATA, b);
      chk_byte("stream_outside", 8'h00, b);
      u_host.bus_read(REG_STAT, b);
      chk_byte("stat_overrun", 8'h02, b);
      u_host.bus_write(REG_STAT, 8'h02);
      u_host.bus_read(REG_STAT, b);
      chk_byte("stat_cleared", 8'h00, b);
      for (int s = 0; s < 4; s++) begin
         u_host.bus_write(REG_SEL, 8'(s));
         typ = u_host.typ_ms(exp_w[9 + 7*s +: 2], exp_w[4 + 7*s +: 5]);
         u_host.read_time(REG_TYP0, t);
         chk_word("typ_time", typ, {8'h00, t});
         u_host.read_time(REG_MAX0, t);
         chk_word("max_time", u_host.max_ms(exp_w[3:0], typ), {8'h00, t});
      end
      // The one-second unit, read right after the select write.
      u_host.bus_write(REG_SEL, 8'h03);
      u_host.bus_read(REG_TYP1, b);
      chk_byte("typ1_unit_1s", 8'h7D, b);
      // A second reset in mid-run restores the pointer and selector.
      u_host.bus_write(REG_PTR, 8'h20);
      u_host.bus_idle();
      srst <= 1'b1;
      @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      u_host.bus_read(REG_PTR, b);
      chk_byte("ptr_rereset", 8'h10, b);
      u_host.bus_read(REG_SEL, b);
      chk_byte("sel_rereset", 8'h00, b);
      summarize();
   end
endmodule : sfdpr_top_bench
